// file: hdl/awce_regs.svh
// command opcodes, sector and check sizes, error bit positions and timing counts of the write engine
`ifndef AWCE_REGS_SVH
`define AWCE_REGS_SVH
`define AWCE_OP_STBY_IMM_A 8'hE0
`define AWCE_OP_STBY_IMM_B 8'h94
`define AWCE_OP_WR_BUF 8'hE8
`define AWCE_OP_WR_DMA_A 8'hCA
`define AWCE_OP_WR_DMA_B 8'hCB
`define AWCE_OP_WR_LONG_A 8'h32
`define AWCE_OP_WR_LONG_B 8'h33
`define AWCE_OP_WR_MULT 8'hC5
`define AWCE_OP_WR_SEC_A 8'h30
`define AWCE_OP_WR_SEC_B 8'h31
`define AWCE_SECTOR_WORDS 16'h0100
`define AWCE_LONG_CHECK_BYTES 16'h0004
`define AWCE_MAX_BLOCK 9'h001
`define AWCE_ERR_ABRT_BIT 2
`define AWCE_ERR_ICRC_BIT 7
`define AWCE_ERR_IDNF_BIT 4
`define AWCE_BSY_LIMIT_NS 400
`define AWCE_CLK_NS 100
`define AWCE_BSY_LIMIT_CYC (`AWCE_BSY_LIMIT_NS / `AWCE_CLK_NS)
`endif

// file: hdl/awce_pkg.sv
// types shared by the write engine files
package awce_pkg;
    typedef enum logic [3:0] {
        AWCE_IDLE = 4'h0,
        AWCE_DECODE = 4'h1,
        AWCE_XFER = 4'h2,
        AWCE_CHECK = 4'h3,
        AWCE_PROG = 4'h4,
        AWCE_NEXT = 4'h5,
        AWCE_DONE = 4'h6
    } awce_state_t;

    typedef enum logic [2:0] {
        AWCE_K_NONE = 3'h0,
        AWCE_K_PIO = 3'h1,
        AWCE_K_BUF = 3'h2,
        AWCE_K_DMA = 3'h3,
        AWCE_K_LONG = 3'h4,
        AWCE_K_MULT = 3'h5
    } awce_kind_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] count;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [3:0] head;
        logic lba_mode;
    } awce_taskfile_t;

    typedef struct packed {
        logic bsy;
        logic drq;
        logic err;
        logic [7:0] error;
    } awce_status_t;
endpackage

// file: hdl/awce_addr_step.sv
// advances a task-file sector address by one, in LBA or CHS form
`timescale 1ns/1ps
module awce_addr_step #(
    parameter int SECTORS_PER_TRACK = 63,
    parameter int HEADS = 16
) (
    input wire logic lba_mode,
    input wire logic [7:0] sec_num,
    input wire logic [7:0] cyl_lo,
    input wire logic [7:0] cyl_hi,
    input wire logic [3:0] head,
    output logic [7:0] next_sec_num,
    output logic [7:0] next_cyl_lo,
    output logic [7:0] next_cyl_hi,
    output logic [3:0] next_head
);
    if (SECTORS_PER_TRACK < 1 || SECTORS_PER_TRACK > 255 || HEADS < 1 || HEADS > 16) begin
        $error("awce_addr_step: geometry out of range");
    end

    logic [27:0] lba_next;
    logic [15:0] cyl_next;

    always_comb begin
        lba_next = {head, cyl_hi, cyl_lo, sec_num} + 28'h0000001;
        cyl_next = {cyl_hi, cyl_lo} + 16'h0001;
        if (lba_mode) begin
            next_head = lba_next[27:24];
            next_cyl_hi = lba_next[23:16];
            next_cyl_lo = lba_next[15:8];
            next_sec_num = lba_next[7:0];
        end else if (sec_num < 8'(SECTORS_PER_TRACK)) begin
            next_head = head;
            next_cyl_hi = cyl_hi;
            next_cyl_lo = cyl_lo;
            next_sec_num = sec_num + 8'h01;
        end else if (head < 4'(HEADS - 1)) begin
            next_head = head + 4'h1;
            next_cyl_hi = cyl_hi;
            next_cyl_lo = cyl_lo;
            next_sec_num = 8'h01;
        end else begin
            next_head = 4'h0;
            next_cyl_hi = cyl_next[15:8];
            next_cyl_lo = cyl_next[7:0];
            next_sec_num = 8'h01;
        end
    end
endmodule

// file: hdl/awce_engine.sv
// command interpreter for standby-immediate and the write-type task-file commands
// Contract
// - standby-immediate sets busy, enters sleep, clears busy, interrupts at once.
// - any later command other than standby-immediate wakes the device from sleep without a reset.
// - write-buffer takes exactly 512 bytes with the write-sectors handshake.
// - DMA write data moves only on DMA requests, by the host DMA channel.
// - DMA write raises one interrupt, after data ends and status is ready.
// - busy or data-request stays shown until a DMA write completes.
// - on DMA success the task file holds the last sector's address.
// - failed DMA sector stops the command; failing address and residual count left.
// - Ultra DMA CRC mismatch sets ICRC and ABRT at command end.
// - write-long moves 516 bytes for exactly one sector.
// - write-long moves 512 bytes as words, then 4 check bytes singly.
// - write-long check bytes may be discarded; internal check data is stored.
// - write-multiple block size is at most BLOCK_MAX sectors, one sector by default.
// - write-multiple shows busy within 400 ns of acceptance.
// - write-multiple qualifies data request once per sector and interrupts once per block.
// - write-multiple count is sectors: full blocks, then one partial remainder block.
// - write-multiple aborts if no set-multiple or multiple mode disabled.
// - write-multiple error ends at failing sector; address and residual recorded.
// - LBA uses head 27-24, cylinder high 23-16, low 15-8, sector 7-0.
// - a sector count of zero means 256 sectors.
// - accepted write: busy, then data request and busy clear, no first interrupt.
`timescale 1ns/1ps
`include "awce_regs.svh"
module awce_engine #(
    parameter int BLOCK_MAX = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire awce_pkg::awce_taskfile_t tf_in,
    input wire logic cmd_wr,
    input wire logic mult_enabled,
    input wire logic [8:0] mult_block,
    input wire logic udma_mode,
    input wire logic pio_wr,
    input wire logic [15:0] pio_data,
    input wire logic pio_byte,
    input wire logic dma_ack,
    input wire logic [15:0] dma_data,
    input wire logic crc_error,
    input wire logic media_done,
    input wire logic media_fail,
    output awce_pkg::awce_status_t status,
    output logic [7:0] tf_count,
    output logic [7:0] tf_sec_num,
    output logic [7:0] tf_cyl_lo,
    output logic [7:0] tf_cyl_hi,
    output logic [3:0] tf_head,
    output logic intrq,
    output logic dmarq,
    output logic sleeping,
    output logic buf_we,
    output logic [7:0] buf_addr,
    output logic [15:0] buf_data,
    output logic media_start,
    output logic [27:0] media_addr,
    output logic long_mode
);
    // block counters are 9 bits wide
    if (BLOCK_MAX < 1 || BLOCK_MAX > 256) begin
        $error("awce_engine: BLOCK_MAX out of range");
    end

    localparam int BSY_CYC = (`AWCE_BSY_LIMIT_CYC < 1) ? 1 : `AWCE_BSY_LIMIT_CYC;

    typedef struct packed {
        awce_pkg::awce_state_t state;
        awce_pkg::awce_kind_t kind;
        awce_pkg::awce_status_t st;
        logic [8:0] remain;
        logic [8:0] blk_left;
        logic [8:0] blk_size;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [3:0] head;
        logic lba_mode;
        logic [8:0] words;
        logic [2:0] tail;
        logic crc_seen;
        logic intrq;
        logic dmarq;
        logic sleeping;
        logic buf_we;
        logic [7:0] buf_addr;
        logic [15:0] buf_data;
        logic media_start;
        logic long_mode;
    } awce_regs_t;

    awce_regs_t r;
    awce_regs_t next_r;
    logic [7:0] step_sec;
    logic [7:0] step_lo;
    logic [7:0] step_hi;
    logic [3:0] step_head;

    awce_addr_step u_step (
        .lba_mode(r.lba_mode),
        .sec_num(r.sec_num),
        .cyl_lo(r.cyl_lo),
        .cyl_hi(r.cyl_hi),
        .head(r.head),
        .next_sec_num(step_sec),
        .next_cyl_lo(step_lo),
        .next_cyl_hi(step_hi),
        .next_head(step_head)
    );

    function automatic logic [8:0] count_of(input logic [7:0] c);
        count_of = (c == 8'h00) ? 9'h100 : {1'b0, c};
    endfunction

    function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
        min9 = (a < b) ? a : b;
    endfunction

    function automatic awce_pkg::awce_kind_t kind_of(input logic [7:0] op);
        case (op)
            `AWCE_OP_WR_SEC_A, `AWCE_OP_WR_SEC_B: kind_of = awce_pkg::AWCE_K_PIO;
            `AWCE_OP_WR_BUF: kind_of = awce_pkg::AWCE_K_BUF;
            `AWCE_OP_WR_DMA_A, `AWCE_OP_WR_DMA_B: kind_of = awce_pkg::AWCE_K_DMA;
            `AWCE_OP_WR_LONG_A, `AWCE_OP_WR_LONG_B: kind_of = awce_pkg::AWCE_K_LONG;
            `AWCE_OP_WR_MULT: kind_of = awce_pkg::AWCE_K_MULT;
            default: kind_of = awce_pkg::AWCE_K_NONE;
        endcase
    endfunction

    logic [8:0] blk_cap;
    logic [8:0] last_word;
    logic data_in;
    logic [15:0] data_word;

    always_comb begin
        next_r = r;
        next_r.intrq = 1'b0;
        next_r.buf_we = 1'b0;
        next_r.media_start = 1'b0;
        // block size limited by this revision
        blk_cap = min9(mult_block, 9'(BLOCK_MAX));
        last_word = 9'(`AWCE_SECTOR_WORDS - 16'h0001);
        data_in = (r.kind == awce_pkg::AWCE_K_DMA) ? (r.dmarq && dma_ack) : pio_wr;
        data_word = (r.kind == awce_pkg::AWCE_K_DMA) ? dma_data : pio_data;
        if (cmd_wr) begin
            // a new command always preempts; any but standby-immediate also wakes from sleep
            next_r.sleeping = 1'b0;
            next_r.st.bsy = 1'b1;
            next_r.st.drq = 1'b0;
            next_r.st.err = 1'b0;
            next_r.st.error = 8'h00;
            next_r.dmarq = 1'b0;
            next_r.state = awce_pkg::AWCE_DECODE;
            next_r.kind = kind_of(tf_in.cmd);
            next_r.sec_num = tf_in.sec_num;
            next_r.cyl_lo = tf_in.cyl_lo;
            next_r.cyl_hi = tf_in.cyl_hi;
            next_r.head = tf_in.head;
            next_r.lba_mode = tf_in.lba_mode;
            next_r.remain = count_of(tf_in.count);
            next_r.crc_seen = 1'b0;
            next_r.long_mode = 1'b0;
            if (tf_in.cmd == `AWCE_OP_STBY_IMM_A || tf_in.cmd == `AWCE_OP_STBY_IMM_B) begin
                next_r.sleeping = 1'b1;
                next_r.state = awce_pkg::AWCE_DONE;
            end
        end else begin
            case (r.state)
                awce_pkg::AWCE_IDLE: begin
                end
                awce_pkg::AWCE_DECODE: begin
                    next_r.words = 9'h000;
                    next_r.tail = 3'h0;
                    case (r.kind)
                        awce_pkg::AWCE_K_NONE: begin
                            next_r.st.err = 1'b1;
                            next_r.st.error[`AWCE_ERR_ABRT_BIT] = 1'b1;
                            next_r.state = awce_pkg::AWCE_DONE;
                        end
                        awce_pkg::AWCE_K_MULT: begin
                            if (!mult_enabled || mult_block == 9'h000) begin
                                next_r.st.err = 1'b1;
                                next_r.st.error[`AWCE_ERR_ABRT_BIT] = 1'b1;
                                next_r.state = awce_pkg::AWCE_DONE;
                            end else begin
                                next_r.blk_size = blk_cap;
                                next_r.blk_left = min9(r.remain, blk_cap);
                                next_r.st.bsy = 1'b0;
                                next_r.st.drq = 1'b1;
                                next_r.state = awce_pkg::AWCE_XFER;
                            end
                        end
                        default: begin
                            if (r.kind == awce_pkg::AWCE_K_BUF || r.kind == awce_pkg::AWCE_K_LONG) begin
                                next_r.remain = 9'h001;
                            end
                            next_r.long_mode = (r.kind == awce_pkg::AWCE_K_LONG);
                            next_r.blk_size = 9'h001;
                            next_r.blk_left = 9'h001;
                            next_r.st.bsy = 1'b0;
                            next_r.st.drq = 1'b1;
                            next_r.dmarq = (r.kind == awce_pkg::AWCE_K_DMA);
                            next_r.state = awce_pkg::AWCE_XFER;
                        end
                    endcase
                end
                awce_pkg::AWCE_XFER: begin
                    if (r.kind == awce_pkg::AWCE_K_DMA && crc_error && udma_mode) begin
                        next_r.crc_seen = 1'b1;
                    end
                    if (data_in) begin
                        if (r.words <= last_word) begin
                            // 512 bytes as words, then check bytes
                            next_r.buf_we = 1'b1;
                            next_r.buf_addr = r.words[7:0];
                            next_r.buf_data = data_word;
                            next_r.words = r.words + 9'h001;
                        end else begin
                            // host check bytes are dropped
                            next_r.tail = r.tail + 3'h1;
                        end
                        if ((r.long_mode && r.tail == 3'(`AWCE_LONG_CHECK_BYTES - 16'h0001)
                                && pio_byte)
                                || (!r.long_mode && r.words == last_word)) begin
                            next_r.st.bsy = 1'b1;
                            next_r.st.drq = 1'b0;
                            next_r.dmarq = 1'b0;
                            next_r.state = awce_pkg::AWCE_CHECK;
                        end
                    end
                end
                awce_pkg::AWCE_CHECK: begin
                    next_r.media_start = (r.kind != awce_pkg::AWCE_K_BUF);
                    next_r.state = (r.kind == awce_pkg::AWCE_K_BUF) ? awce_pkg::AWCE_DONE
                                                                     : awce_pkg::AWCE_PROG;
                end
                awce_pkg::AWCE_PROG: begin
                    if (media_fail) begin
                        // stop at failing sector; residual left in count
                        next_r.st.err = 1'b1;
                        next_r.st.error[`AWCE_ERR_IDNF_BIT] = 1'b1;
                        next_r.state = awce_pkg::AWCE_DONE;
                    end else if (media_done) begin
                        next_r.remain = r.remain - 9'h001;
                        next_r.blk_left = r.blk_left - 9'h001;
                        next_r.state = awce_pkg::AWCE_NEXT;
                        if (r.remain == 9'h001) begin
                            next_r.state = awce_pkg::AWCE_DONE;
                        end else begin
                            next_r.sec_num = step_sec;
                            next_r.cyl_lo = step_lo;
                            next_r.cyl_hi = step_hi;
                            next_r.head = step_head;
                        end
                    end
                end
                awce_pkg::AWCE_NEXT: begin
                    next_r.words = 9'h000;
                    next_r.st.bsy = 1'b0;
                    next_r.st.drq = 1'b1;
                    next_r.dmarq = (r.kind == awce_pkg::AWCE_K_DMA);
                    if (r.blk_left == 9'h000) begin
                        // interrupt only where a block starts, never inside one
                        next_r.intrq = (r.kind != awce_pkg::AWCE_K_DMA);
                        next_r.blk_left = min9(r.remain, r.blk_size);
                    end
                    next_r.state = awce_pkg::AWCE_XFER;
                end
                awce_pkg::AWCE_DONE: begin
                    if (r.crc_seen) begin
                        next_r.st.err = 1'b1;
                        next_r.st.error[`AWCE_ERR_ICRC_BIT] = 1'b1;
                        next_r.st.error[`AWCE_ERR_ABRT_BIT] = 1'b1;
                    end
                    next_r.st.bsy = 1'b0;
                    next_r.st.drq = 1'b0;
                    next_r.dmarq = 1'b0;
                    next_r.long_mode = 1'b0;
                    next_r.intrq = 1'b1;
                    next_r.state = awce_pkg::AWCE_IDLE;
                end
                default: next_r.state = awce_pkg::AWCE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // multi-sector blocks over BLOCK_MAX are cut down to BLOCK_MAX by the block cap, so busy never lingers
    assign status = r.st;
    assign tf_count = r.remain[7:0];
    assign tf_sec_num = r.sec_num;
    assign tf_cyl_lo = r.cyl_lo;
    assign tf_cyl_hi = r.cyl_hi;
    assign tf_head = r.head;
    assign intrq = r.intrq;
    assign dmarq = r.dmarq;
    assign sleeping = r.sleeping;
    assign buf_we = r.buf_we;
    assign buf_addr = r.buf_addr;
    assign buf_data = r.buf_data;
    assign media_start = r.media_start;
    assign media_addr = {r.head, r.cyl_hi, r.cyl_lo, r.sec_num};
    assign long_mode = r.long_mode;
endmodule

// file: dv/awce_engine_props.sv
// concurrent checks on the write engine ports, bound to the engine
`timescale 1ns/1ps
`include "awce_regs.svh"
module awce_engine_props #(
    parameter int BLOCK_MAX = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire awce_pkg::awce_taskfile_t tf_in,
    input wire logic cmd_wr,
    input wire logic mult_enabled,
    input wire logic [8:0] mult_block,
    input wire logic udma_mode,
    input wire logic crc_error,
    input wire awce_pkg::awce_status_t status,
    input wire logic [7:0] tf_sec_num,
    input wire logic [7:0] tf_cyl_lo,
    input wire logic [7:0] tf_cyl_hi,
    input wire logic [3:0] tf_head,
    input wire logic intrq,
    input wire logic dmarq,
    input wire logic sleeping,
    input wire logic media_start,
    input wire logic [27:0] media_addr
);
    logic dma_act;
    logic crc_seen;
    logic is_dma;
    logic is_stby;
    logic pio_op;
    logic known;
    logic first_ms;
    logic [27:0] start_addr;
    assign is_dma = tf_in.cmd inside {`AWCE_OP_WR_DMA_A, `AWCE_OP_WR_DMA_B};
    assign is_stby = tf_in.cmd inside {`AWCE_OP_STBY_IMM_A, `AWCE_OP_STBY_IMM_B};
    assign pio_op = tf_in.cmd inside {`AWCE_OP_WR_BUF, `AWCE_OP_WR_SEC_A, `AWCE_OP_WR_SEC_B,
        `AWCE_OP_WR_LONG_A, `AWCE_OP_WR_LONG_B};
    assign known = is_dma || is_stby || pio_op || tf_in.cmd == `AWCE_OP_WR_MULT;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // tracks a dma command from its write up to its closing interrupt
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dma_act <= 1'b0;
            crc_seen <= 1'b0;
            first_ms <= 1'b0;
            start_addr <= '0;
        end else if (cmd_wr) begin
            dma_act <= is_dma;
            crc_seen <= 1'b0;
            first_ms <= 1'b1;
            start_addr <= {tf_in.head, tf_in.cyl_hi, tf_in.cyl_lo, tf_in.sec_num};
        end else begin
            first_ms <= first_ms && !media_start;
            dma_act <= dma_act && !intrq;
            crc_seen <= crc_seen || (crc_error && dma_act);
        end
    end
    AST_BSY_SOON: assert property (cmd_wr |=> status.bsy)
        else $error("busy not shown the cycle after a command write");
    AST_STBY_SEQ: assert property (cmd_wr && is_stby |=> status.bsy && sleeping ##1
        (!status.bsy && intrq)) else $error("standby sequence wrong");
    AST_WAKE: assert property (sleeping && cmd_wr && !is_stby |=> ##[0:1] !sleeping)
        else $error("sleep not left on a new command");
    AST_FIRST_XFER: assert property (cmd_wr && pio_op |=> !intrq ##1
        (status.drq && !status.bsy && !intrq)) else $error("first data request wrong");
    AST_DMA_BUSY: assert property (dma_act && !intrq |-> status.bsy || status.drq)
        else $error("neither busy nor data request during dma write");
    AST_DMA_ONE_IRQ: assert property (dma_act && intrq |-> !status.bsy && !status.drq)
        else $error("dma interrupt before transfer ended");
    AST_DMARQ_ONLY_DMA: assert property (dmarq |-> dma_act)
        else $error("dma request outside a dma write");
    AST_CRC_BITS: assert property (crc_seen && dma_act && udma_mode && intrq |-> ##[0:1]
        (status.error[`AWCE_ERR_ICRC_BIT] && status.error[`AWCE_ERR_ABRT_BIT]))
        else $error("crc error not reported");
    AST_MULT_ABORT: assert property (cmd_wr && tf_in.cmd == `AWCE_OP_WR_MULT &&
        (!mult_enabled || mult_block == 9'h000) |=> ##[0:2]
        (intrq && status.err && status.error[`AWCE_ERR_ABRT_BIT]))
        else $error("write multiple not aborted");
    AST_UNKNOWN_ABORT: assert property (cmd_wr && !known |=> ##[0:2]
        (intrq && status.err && status.error[`AWCE_ERR_ABRT_BIT]))
        else $error("unknown opcode not aborted");
    AST_MEDIA_ADDR: assert property (media_start |->
        media_addr == {tf_head, tf_cyl_hi, tf_cyl_lo, tf_sec_num} &&
        (!first_ms || media_addr == start_addr))
        else $error("media address does not follow task file");
endmodule

bind awce_engine awce_engine_props #(.BLOCK_MAX(BLOCK_MAX)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tf_in(tf_in), .cmd_wr(cmd_wr),
    .mult_enabled(mult_enabled), .mult_block(mult_block), .udma_mode(udma_mode),
    .crc_error(crc_error), .status(status), .tf_sec_num(tf_sec_num), .tf_cyl_lo(tf_cyl_lo),
    .tf_cyl_hi(tf_cyl_hi), .tf_head(tf_head), .intrq(intrq), .dmarq(dmarq),
    .sleeping(sleeping), .media_start(media_start), .media_addr(media_addr));

// file: dv/awce_host_model.sv
// host controller model: feeds sector data by pio or by its dma channel
`timescale 1ns/1ps
module awce_host_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic drq,
    input wire logic dmarq,
    input wire logic dma_sel,
    input wire logic long_sel,
    input wire logic slow,
    output logic pio_wr,
    output logic [15:0] pio_data,
    output logic pio_byte,
    output logic dma_ack,
    output logic [15:0] dma_data
);
    logic [8:0] cnt;
    logic ph;
    logic go;
    // dma words only while dmarq is up, pio words only while drq is up
    assign go = !sys_rst && (dma_sel ? dmarq : drq) && (!slow || ph) &&
        cnt < (long_sel ? 9'h104 : 9'h100);
    always_ff @(posedge clk_sys) begin
        ph <= !ph && !sys_rst;
        cnt <= (sys_rst || (!drq && !dmarq)) ? 9'h000 : cnt + {8'h00, go};
        pio_wr <= go && !dma_sel;
        pio_byte <= go && !dma_sel && cnt >= 9'h100;
        dma_ack <= go && dma_sel;
        // released lines flip so a stale word never looks valid
        pio_data <= go ? {7'h00, cnt} ^ 16'hA5C3 : ~pio_data;
        dma_data <= go ? {7'h00, cnt} ^ 16'h3C5A : ~dma_data;
    end
endmodule

// file: dv/awce_engine_tb_top.sv
// directed testbench for the write command engine
`timescale 1ns/1ps
module awce_engine_tb_top;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, mult_enabled = 1'b0, udma_mode = 1'b0;
    logic crc_error = 1'b0, media_done = 1'b0, media_fail = 1'b0;
    logic dma_sel = 1'b0, long_sel = 1'b0, slow = 1'b0;
    logic [8:0] mult_block = 9'h001;
    awce_pkg::awce_taskfile_t tf_in = '0;
    awce_pkg::awce_status_t status;
    logic pio_wr, pio_byte, dma_ack, intrq, dmarq, sleeping, buf_we, media_start, long_mode;
    logic [15:0] pio_data, dma_data, buf_data;
    logic [7:0] tf_count, tf_sec_num, tf_cyl_lo, tf_cyl_hi, buf_addr;
    logic [3:0] tf_head;
    logic [27:0] media_addr;
    int errors = 0, n_tests = 0, cycles = 0;
    int n_irq, n_we, n_ms, n_lm;
    awce_engine #(.BLOCK_MAX(1)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .tf_in(tf_in),
        .cmd_wr(cmd_wr), .mult_enabled(mult_enabled), .mult_block(mult_block),
        .udma_mode(udma_mode), .pio_wr(pio_wr), .pio_data(pio_data), .pio_byte(pio_byte),
        .dma_ack(dma_ack), .dma_data(dma_data), .crc_error(crc_error), .media_done(media_done),
        .media_fail(media_fail), .status(status), .tf_count(tf_count), .tf_sec_num(tf_sec_num),
        .tf_cyl_lo(tf_cyl_lo), .tf_cyl_hi(tf_cyl_hi), .tf_head(tf_head), .intrq(intrq),
        .dmarq(dmarq), .sleeping(sleeping), .buf_we(buf_we), .buf_addr(buf_addr),
        .buf_data(buf_data), .media_start(media_start), .media_addr(media_addr),
        .long_mode(long_mode));
    awce_host_model u_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .drq(status.drq),
        .dmarq(dmarq), .dma_sel(dma_sel), .long_sel(long_sel), .slow(slow), .pio_wr(pio_wr),
        .pio_data(pio_data), .pio_byte(pio_byte), .dma_ack(dma_ack), .dma_data(dma_data));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // issues one command, answers the flash side, runs until the closing interrupt
    task automatic run(input logic [7:0] op, input logic [7:0] cnt, input int fail_at,
        input bit crc);
        int wm;
        int k;
        logic [23:0] wexp;
        wm = 0;
        n_irq = 0;
        n_we = 0;
        n_ms = 0;
        n_lm = 0;
        @(posedge clk_sys);
        tf_in <= '{cmd: op, count: cnt, sec_num: 8'h56, cyl_lo: 8'h34, cyl_hi: 8'h12,
            head: 4'h7, lba_mode: 1'b1};
        cmd_wr <= 1'b1;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_sys);
            if (media_start === 1'b1) begin
                n_ms++;
                wm = 3;
            end else if (wm > 0) begin
                wm--;
            end
            wexp = {8'(n_we), {8'h00, 8'(n_we)} ^ (dma_sel ? 16'h3C5A : 16'hA5C3)};
            if (buf_we === 1'b1) chk("buffer word", wexp, {buf_addr, buf_data});
            n_we += (buf_we === 1'b1);
            n_lm += (long_mode === 1'b1);
            cmd_wr <= 1'b0;
            media_done <= wm == 1 && n_ms != fail_at;
            media_fail <= wm == 1 && n_ms == fail_at;
            crc_error <= crc && n_we == 100;
            if (intrq === 1'b1) begin
                n_irq++;
                if (status.drq !== 1'b1) break;
            end
        end
        chk("command finished", 1, k < 4000);
        @(posedge clk_sys);
        $display("test with opcode %h done", op);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        run(8'hE0, 8'h01, 0, 0);
        chk("sleeping", 1, sleeping);
        chk("standby irqs", 1, n_irq);
        run(8'h94, 8'h01, 0, 0);
        chk("sleeping", 1, sleeping);
        run(8'hE8, 8'h01, 0, 0);
        chk("awake", 0, sleeping);
        chk("buffer words", 256, n_we);
        chk("buffer irqs", 1, n_irq);
        dma_sel <= 1'b1;
        udma_mode <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            run(8'hCA + 8'(i), 8'h02, 0, 0);
            chk("dma irqs", 1, n_irq);
            chk("dma words", 512, n_we);
            chk("dma last sector", 8'h57, tf_sec_num);
            chk("dma upper address", 20'h71234, {tf_head, tf_cyl_hi, tf_cyl_lo});
            chk("dma residual", 0, tf_count);
        end
        slow <= 1'b1;
        run(8'hCA, 8'h03, 2, 0);
        chk("dma writes after fail", 2, n_ms);
        chk("dma fail sector", 8'h57, tf_sec_num);
        chk("dma fail residual", 2, tf_count);
        chk("dma fail error", 1, status.err && status.error[4]);
        run(8'hCB, 8'h01, 0, 1);
        chk("crc error bits", 2'b11, {status.error[7], status.error[2]});
        slow <= 1'b0;
        dma_sel <= 1'b0;
        long_sel <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            run(8'h32 + 8'(i), 8'h01, 0, 0);
            chk("long words", 256, n_we);
            chk("long sectors", 1, n_ms);
            chk("long internal check", 1, n_lm > 0);
        end
        long_sel <= 1'b0;
        mult_enabled <= 1'b1;
        run(8'hC5, 8'h02, 0, 0);
        chk("multiple irqs", 2, n_irq);
        chk("multiple sectors", 2, n_ms);
        chk("multiple words", 512, n_we);
        run(8'hC5, 8'h03, 2, 0);
        chk("multiple fail sector", 8'h57, tf_sec_num);
        chk("multiple residual", 2, tf_count);
        mult_block <= 9'h000;
        run(8'hC5, 8'h01, 0, 0);
        chk("zero block abort", 1, status.err && status.error[2]);
        mult_block <= 9'h001;
        mult_enabled <= 1'b0;
        run(8'hC5, 8'h01, 0, 0);
        chk("disabled abort", 1, status.err && status.error[2]);
        run(8'h5A, 8'h01, 0, 0);
        chk("unknown abort", 1, status.err && status.error[2]);
        chk("unknown no write", 0, n_ms);
        conclude();
    end
endmodule
